// ===== tb/adcsq_host_model.sv
`timescale 1ns/1ps
// ==========================================
// host end of the serial link, mode 1 master
module adcsq_host_model (
  output logic      sclk,
  output logic      csN,
  output logic      din,
  input  wire logic doutLine
);
  initial begin
    {sclk, csN, din} = 3'h2; // clock idles low
  end
  // one frame of nBits, msb first; fewer than 16 aborts it
  task automatic xfer(input logic [15:0] w, input int nBits, output logic [15:0] rx);
    rx = 16'h0;
    #37;
    csN = 1'b0; // held low all frame
    #400;
    for (int i = 0; i < nBits; i++) begin
      sclk = 1'b1;
      din = w[15 - i]; // launch on rise
      #400;
      sclk = 1'b0;
      rx = {rx[14:0], doutLine}; // sample on fall
      #400;
    end
    csN = 1'b1;
    din = ~din; // released line never keeps its last bit
    #800;
  endtask
endmodule

// ===== tb/adcsq_sequencer_properties.sv
`timescale 1ns/1ps
// ==========================================
// pin checks of the conversion sequencer
module adcsq_sequencer_properties
  import adcsq_pkg::*;
(
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic csPinN,
  input wire logic doutOeN,
  input wire logic dataReadyN,
  input wire logic chopPolarity,
  input wire logic filterReset,
  input wire logic channelEnable,
  input wire logic phaseCalEnable,
  input wire logic dcTestEnable
);
  // one domain, so one default clock and reset
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);
  // ==========================================
  // bus and link
  property p_ack_next;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  a_ack_next: assert property (p_ack_next) else $error("bus ack late or long");
  // five cycles covers the two-flop pin synchroniser
  property p_dout_free;
    csPinN [*5] |-> doutOeN;
  endproperty
  a_dout_free: assert property (p_dout_free) else $error("dout driven");
  // ==========================================
  // sequencing
  property p_data_ready_n_width;
    $fell(dataReadyN) |-> !dataReadyN [*4] ##1 dataReadyN;
  endproperty
  a_data_ready_n_width: assert property (p_data_ready_n_width) else $error("data_ready_n pulse width");
  property p_phase_off;
    chopPolarity |-> !phaseCalEnable;
  endproperty
  a_phase_off: assert property (p_phase_off) else $error("phase cal in chop");
  property p_dc_off;
    chopPolarity |-> !dcTestEnable;
  endproperty
  a_dc_off: assert property (p_dc_off) else $error("dc test in chop");
  property p_standby_quiet;
    !channelEnable [*5] |-> dataReadyN;
  endproperty
  a_standby_quiet: assert property (p_standby_quiet) else $error("data_ready_n in standby");
  property p_swap_reset;
    $rose(chopPolarity) |-> filterReset;
  endproperty
  a_swap_reset: assert property (p_swap_reset) else $error("swap without reset");
  // shortest settle delay is two modulator periods
  property p_swap_delay;
    $rose(filterReset) |-> filterReset [*2];
  endproperty
  a_swap_delay: assert property (p_swap_delay) else $error("settle delay short");
endmodule
bind adcsq_sequencer adcsq_sequencer_properties chk_u (.mclk(mclk), .arst_n(arst_n),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .csPinN(csPinN),
  .doutOeN(doutOeN), .dataReadyN(dataReadyN), .chopPolarity(chopPolarity),
  .filterReset(filterReset), .channelEnable(channelEnable),
  .phaseCalEnable(phaseCalEnable), .dcTestEnable(dcTestEnable));

// ===== tb/tb_adcsq_sequencer.sv
`timescale 1ns/1ps
// ==========================================
// self-checking bench for the conversion sequencer
module tb_adcsq_sequencer
  import adcsq_pkg::*;
;
  typedef struct packed {logic [31:0] lo; logic [31:0] hi;} adcsq_win_t;
  localparam logic [23:0] VIN = 24'h001000; // true input
  localparam logic [23:0] OFS = 24'h000200; // core offset, chop cancels it
  logic        mclk, arstN, wbCyc, wbStb, wbWe, wbAck, drdyPrev;
  logic        sclk, csN, din, dout, oeN, doutLine, drdyN, syncN;
  logic        pol, fRst, chEn, refUp, phEn, dcEn, isoEn;
  logic [1:0]  bias;
  logic [3:0]  wbSel, dSel;
  logic [7:0]  wbAdr;
  logic [15:0] rx;
  logic [23:0] sample;
  logic [31:0] wbDw, wbDr, cyc, lastT, pGc;
  int          errCount, numChecks, seed;
  logic [31:0] rdQ[$]; // expected read data
  adcsq_win_t  perQ[$]; // expected data_ready_n spacing
  adcsq_win_t  w;
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  // reversed polarity flips the input but not the offset
  assign sample = pol ? OFS - VIN : VIN + OFS;
  assign doutLine = oeN ? cyc[0] : dout; // released line toggles
  adcsq_sequencer #(.MOD_DIV(1), .DATA_READY_N_LOW_CYC(4), .RESET_THRESH_CYC(64)) dut_u (
    .mclk(mclk), .arst_n(arstN), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe),
    .wb_adr_i(wbAdr), .wb_dat_i(wbDw), .wb_sel_i(wbSel), .wb_dat_o(wbDr), .wb_ack_o(wbAck),
    .sclkPin(sclk), .csPinN(csN), .dinPin(din), .doutPin(dout), .doutOeN(oeN),
    .dataReadyN(drdyN), .syncResetPinN(syncN), .convSample(sample), .chopPolarity(pol),
    .filterReset(fRst), .channelEnable(chEn), .refPowerUp(refUp), .biasMode(bias),
    .phaseCalEnable(phEn), .dcTestEnable(dcEn), .isoSupplyEnable(isoEn));
  adcsq_host_model host_u (.sclk(sclk), .csN(csN), .din(din), .doutLine(doutLine));
  // ==========================================
  // checking and closing
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    numChecks++;
    if (got !== exp) begin
      errCount++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic giveVerdict();
    $display("checks %0d, mismatches %0d", numChecks, errCount);
    if (errCount == 0 && numChecks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  function automatic logic [31:0] ctrlWord(input logic c, input logic [3:0] d,
      input logic [1:0] p, input logic [2:0] o, input logic ph, input logic dc);
    return {13'h0, dc, ph, 2'h0, o, 2'h0, p, d, 3'h0, c};
  endfunction
  // classic cycle, held until ack is sampled high
  task automatic wbXfer(input logic we, input logic [7:0] adr, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    {wbCyc, wbStb, wbWe, wbAdr, wbDw} <= {2'h3, we, adr, d};
    do begin
      @(posedge mclk);
      n++;
    end while (wbAck !== 1'b1 && n < 40);
    {wbCyc, wbStb} <= 2'h0;
    if (wbAck !== 1'b1) begin
      check("bus ack", 32'h1, 32'h0);
      giveVerdict();
    end
  endtask
  task automatic wbRead(input logic [7:0] adr, input logic [31:0] exp);
    rdQ.push_back(exp);
    wbXfer(1'b0, adr, 32'h0);
  endtask
  // note data_ready_n spacings, then wait until all are seen
  task automatic gaps(input logic [31:0] f, input logic [31:0] s, input logic [31:0] p, int n);
    int k;
    k = 0;
    perQ.push_back('{f, f + s});
    for (int i = 0; i < n; i++)
      perQ.push_back('{p, p});
    while (perQ.size() > 0 && k < 5000) begin
      @(posedge mclk);
      k++;
    end
    if (perQ.size() > 0) begin
      check("data_ready_n count", 32'h0, perQ.size());
      giveVerdict();
    end
  endtask
  // ==========================================
  // watcher: each answer against the oldest note
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (wbAck === 1'b1 && wbWe === 1'b0 && rdQ.size() > 0)
      check("read data", rdQ.pop_front(), wbDr);
    if (drdyPrev === 1'b1 && drdyN === 1'b0) begin
      if (perQ.size() > 0) begin
        w = perQ.pop_front();
        check("data_ready_n gap", w.lo, (cyc - lastT) inside {[w.lo:w.hi]} ? w.lo : cyc - lastT);
      end
      lastT = cyc;
    end
    drdyPrev = drdyN;
  end
  // ==========================================
  // main sequence
  initial begin
    seed = 32'h666D81C2;
    {wbCyc, wbStb, wbWe, arstN, syncN, drdyPrev} = 6'h03;
    {wbAdr, wbDw, wbSel, cyc, lastT} = {8'h00, 32'h0, 4'hF, 32'h0, 32'h0};
    repeat (3) @(posedge mclk);
    arstN <= 1'b1;
    check("idle dout enable", 32'h1, {31'h0, oeN});
    wbRead(OFS_CTRL, ctrlWord(1'b0, DLY_RESET, PWR_RESET, OSR_RESET, 1'b0, 1'b0));
    $display("test reset done");
    for (int p = 0; p < 4; p++) begin
      wbXfer(1'b1, OFS_CTRL,
             ctrlWord(1'b0, 4'h0, p[1:0], 3'h0, 1'b1, 1'b1) | {15'h0, p[0], 16'h0});
      #10;
      check("bias", {30'h0, p[1:0]}, {30'h0, bias});
      check("iso supply", {31'h0, p[0]}, {31'h0, isoEn});
      check("phase and dc on", 32'h3, {30'h0, phEn, dcEn});
    end
    gaps(1, 2000, 128, 2);
    wbRead(OFS_RESULT, {8'h0, VIN + OFS});
    $display("test continuous done");
    dSel = 4'($random(seed)) & 4'h3;
    pGc = (32'h2 << dSel) + 3 * 128;
    wbXfer(1'b1, OFS_CTRL, ctrlWord(1'b1, dSel, 2'h2, 3'h0, 1'b1, 1'b1));
    lastT = cyc;
    #10;
    check("phase and dc off", 32'h0, {30'h0, phEn, dcEn});
    gaps(2 * pGc + 44, 3, pGc, 2);
    wbRead(OFS_RESULT, {8'h0, VIN});
    @(posedge mclk);
    syncN <= 1'b0;
    lastT = cyc;
    repeat (4) @(posedge mclk);
    syncN <= 1'b1;
    gaps(2 * pGc + 44, 6, pGc, 1);
    wbRead(OFS_CTRL, ctrlWord(1'b1, dSel, 2'h2, 3'h0, 1'b1, 1'b1));
    pGc = (32'h2 << dSel) + 3 * 256;
    wbXfer(1'b1, OFS_CTRL, ctrlWord(1'b1, dSel, 2'h2, 3'h1, 1'b1, 1'b1));
    lastT = cyc;
    gaps(2 * pGc + 44, 3, pGc, 1);
    wbRead(8'h0C, 32'h0);
    $display("test chop done");
    wbXfer(1'b1, OFS_CTRL, ctrlWord(1'b0, 4'h0, 2'h2, 3'h0, 1'b0, 1'b0));
    host_u.xfer(16'hFFFF, 7, rx);
    host_u.xfer({8'hA5, 8'($random(seed))}, 16, rx);
    host_u.xfer(CMD_STANDBY, 16, rx);
    check("standby outputs", 32'h0, {30'h0, chEn, refUp});
    wbRead(OFS_STATUS, 32'h1);
    host_u.xfer(CMD_WAKEUP, 16, rx);
    check("dout word", 32'h0100, {16'h0, rx});
    check("awake outputs", 32'h3, {30'h0, chEn, refUp});
    gaps(1, 2000, 128, 1);
    $display("test link done");
    syncN <= 1'b0;
    repeat (70) @(posedge mclk);
    syncN <= 1'b1;
    repeat (4) @(posedge mclk);
    wbRead(OFS_CTRL, ctrlWord(1'b0, DLY_RESET, PWR_RESET, OSR_RESET, 1'b0, 1'b0));
    $display("test soft reset done");
    giveVerdict();
  end
endmodule

// ===== verilog/adcsq_pkg.sv
// ============================================================
// shared constants and carriers for the conversion sequencer
package adcsq_pkg;

  // ==========================================================
  // register map, byte addresses on the wishbone bus
  localparam logic [7:0]  OFS_CTRL       = 8'h00;
  localparam logic [7:0]  OFS_STATUS     = 8'h04;
  localparam logic [7:0]  OFS_RESULT     = 8'h08;

  // control word field positions
  localparam int          CTRL_CHOP      = 0;   // chop_enable_bit
  localparam int          CTRL_DLY_LSB   = 4;   // chop_settle_delay_field, 4 bits
  localparam int          CTRL_PWR_LSB   = 8;   // power_mode_field, 2 bits
  localparam int          CTRL_OSR_LSB   = 12;  // oversampling select, 3 bits
  localparam int          CTRL_ISO       = 16;  // isolated_supply_enable_bit
  localparam int          CTRL_PHASE     = 17;  // phase calibration request
  localparam int          CTRL_DCTEST    = 18;  // dc test signal request

  // status word field positions
  localparam int          STAT_STANDBY   = 0;
  localparam int          STAT_POLARITY  = 1;
  localparam int          STAT_CHOP      = 2;
  localparam int          STAT_PHASE     = 3;
  localparam int          STAT_DCTEST    = 4;
  localparam int          STAT_FIRST     = 5;

  // reset values of control fields
  localparam logic [3:0]  DLY_RESET      = 4'h0;
  localparam logic [1:0]  PWR_RESET      = 2'h2;
  localparam logic [2:0]  OSR_RESET      = 3'h3;

  // ==========================================================
  // serial commands and framing
  localparam logic [15:0] CMD_STANDBY    = 16'h0022;
  localparam logic [15:0] CMD_WAKEUP     = 16'h0033;
  localparam logic [4:0]  WORD_BITS      = 5'h10;

  // ==========================================================
  // conversion timing, in modulator periods
  localparam logic [31:0] OSR_BASE       = 32'h0000_0080;  // smallest ratio, 128
  localparam logic [31:0] CHOP_CONV_MUL  = 32'h0000_0003;  // filter settles in three
  localparam logic [5:0]  FIRST_EXTRA    = 6'h2C;          // 44 periods on first result
  localparam logic [15:0] SYNC_MIN_CYC   = 16'h0002;       // low longer than one mclk

  typedef enum logic [1:0] {SQ_DELAY, SQ_CONV, SQ_HALT} adcsq_seq_t;

  // software configuration
  typedef struct packed {
    logic       chopEn;
    logic [3:0] dlySel;
    logic [1:0] pwr;
    logic [2:0] osrSel;
    logic       isoEn;
    logic       phaseReq;
    logic       dcReq;
  } adcsq_cfg_t;

  // synchronised pins and their previous values
  typedef struct packed {
    logic [1:0] sclkS;
    logic [1:0] csS;
    logic [1:0] dinS;
    logic [1:0] syncS;
    logic       sclkPrev;
    logic       csPrev;
    logic       syncPrev;
  } adcsq_pins_t;

  // serial shifter
  typedef struct packed {
    logic [15:0] rx;
    logic [15:0] tx;
    logic [4:0]  bitCnt;
    logic        dout;
    logic        doutOeN;
  } adcsq_spi_t;

  // whole state of the sequencer
  typedef struct packed {
    adcsq_pins_t pins;
    adcsq_spi_t  spi;
    adcsq_cfg_t  cfg;
    adcsq_seq_t  seq;
    logic [15:0] modCnt;
    logic [31:0] cnt;
    logic        polarity;
    logic        havePrev;
    logic        firstPend;
    logic [5:0]  extraCnt;
    logic [24:0] prevCorr;
    logic [23:0] result;
    logic [23:0] pendResult;
    logic        standby;
    logic        drdyN;
    logic [7:0]  drdyCnt;
    logic [15:0] syncLow;
    logic        phaseOn;
    logic        dcOn;
    logic        ack;
    logic [31:0] rdata;
    logic        filterRst;
    logic        chanOn;
  } adcsq_state_t;

endpackage

// ===== verilog/adcsq_sequencer.sv
`timescale 1ns/1ps
// Overview of operation
// - continuous mode: result each ratio modulator periods
// - chop mode alternates input polarity each conversion
// - chop output averages sliding opposite-polarity pairs
// - filter reset on swap, three ratios per conversion
// - settle delay after swap, two to 65536
// - chop period equals delay plus three ratios
// - chop restarts on sync fall or ratio change
// - first chop result: two periods plus 44
// - phase calibration forced off during chop mode
// - dc test signal unavailable during chop mode
// - power field scales bias in both modes
// - command 0022h enters standby, keeps settings
// - command 0033h leaves standby, resumes converting
// - serial link is mode 1, clock idles low
// - shift out on rise, sample on fall
// - chip select high: ignore link, release output
// - chip select rise resets serial state
// - peripheral only, full duplex transfer
// - short sync low synchronises, long low resets
// - data ready active low, spaced by data period
module adcsq_sequencer
  import adcsq_pkg::*;
#(
  parameter int MOD_DIV          = 1,     // mclk cycles per modulator period
  parameter int DATA_READY_N_LOW_CYC     = 4,     // width of the data ready low pulse
  parameter int RESET_THRESH_CYC = 4096   // sync low for this many cycles resets
) (
  input  wire logic        mclk,
  input  wire logic        arst_n,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [3:0]  wb_sel_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // serial link pins
  input  wire logic        sclkPin,
  input  wire logic        csPinN,
  input  wire logic        dinPin,
  output logic             doutPin,
  output logic             doutOeN,
  // data ready and sync
  output logic             dataReadyN,
  input  wire logic        syncResetPinN,
  // analog core side
  input  wire logic [23:0] convSample,
  output logic             chopPolarity,
  output logic             filterReset,
  output logic             channelEnable,
  output logic             refPowerUp,
  output logic [1:0]       biasMode,
  output logic             phaseCalEnable,
  output logic             dcTestEnable,
  output logic             isoSupplyEnable
);

  // ==========================================================
  // elaboration checks
  if (MOD_DIV < 1 || MOD_DIV > 65535) begin : g_chk_div
    $error("MOD_DIV out of range");
  end
  if (DATA_READY_N_LOW_CYC < 1 || DATA_READY_N_LOW_CYC > 255) begin : g_chk_data_ready_n
    $error("DATA_READY_N_LOW_CYC out of range");
  end
  if (RESET_THRESH_CYC <= 2 || RESET_THRESH_CYC > 65535) begin : g_chk_rst
    $error("RESET_THRESH_CYC out of range");
  end

  localparam logic [15:0] MOD_LAST   = 16'(MOD_DIV - 1);
  localparam logic [7:0]  DATA_READY_N_LAST  = 8'(DATA_READY_N_LOW_CYC - 1);
  localparam logic [15:0] RESET_LAST = 16'(RESET_THRESH_CYC - 1);

  // ==========================================================
  // reset image of the whole state
  function automatic adcsq_state_t init_state();
    adcsq_state_t s;
    s                = '0;
    s.pins.csS       = 2'h3;
    s.pins.csPrev    = 1'b1;
    s.pins.syncS     = 2'h3;
    s.pins.syncPrev  = 1'b1;
    s.spi.doutOeN    = 1'b1;
    s.cfg.dlySel     = DLY_RESET;
    s.cfg.pwr        = PWR_RESET;
    s.cfg.osrSel     = OSR_RESET;
    s.seq            = SQ_CONV;
    s.drdyN          = 1'b1;
    s.chanOn         = 1'b1;
    return s;
  endfunction
  localparam adcsq_state_t ST_INIT = init_state();

  // control word packing
  function automatic logic [31:0] cfg_word(input adcsq_cfg_t c);
    logic [31:0] w;
    w                                    = '0;
    w[CTRL_CHOP]                         = c.chopEn;
    w[CTRL_DLY_LSB +: 4]                 = c.dlySel;
    w[CTRL_PWR_LSB +: 2]                 = c.pwr;
    w[CTRL_OSR_LSB +: 3]                 = c.osrSel;
    w[CTRL_ISO]                          = c.isoEn;
    w[CTRL_PHASE]                        = c.phaseReq;
    w[CTRL_DCTEST]                       = c.dcReq;
    return w;
  endfunction
  adcsq_state_t r_reg;    // registered state
  adcsq_state_t r_next;   // its next value

  // ==========================================================
  // next-state logic
  always_comb begin
    logic        sclkRise;
    logic        sclkFall;
    logic        csLow;
    logic        csFall;
    logic        syncFall;
    logic        modTick;
    logic        restart;
    logic        emit;
    logic        busHit;
    logic        softReset;
    logic [31:0] mask;
    logic [31:0] wword;
    logic [31:0] osrLen;
    logic [31:0] convLen;
    logic [31:0] dlyLen;
    logic [24:0] corr;
    logic [24:0] sum;
    logic [15:0] word;
    adcsq_cfg_t  newCfg;
    sclkRise  = 1'b0;
    sclkFall  = 1'b0;
    csLow     = 1'b0;
    csFall    = 1'b0;
    syncFall  = 1'b0;
    modTick   = 1'b0;
    restart   = 1'b0;
    emit      = 1'b0;
    busHit    = 1'b0;
    softReset = 1'b0;
    mask      = '0;
    wword     = '0;
    osrLen    = '0;
    convLen   = '0;
    dlyLen    = '0;
    corr      = '0;
    sum       = '0;
    word      = '0;
    newCfg    = r_reg.cfg;
    r_next    = r_reg;
    // pin synchronisers, edges seen on the second stage only
    r_next.pins.sclkS    = {r_reg.pins.sclkS[0], sclkPin};
    r_next.pins.csS      = {r_reg.pins.csS[0], csPinN};
    r_next.pins.dinS     = {r_reg.pins.dinS[0], dinPin};
    r_next.pins.syncS    = {r_reg.pins.syncS[0], syncResetPinN};
    r_next.pins.sclkPrev = r_reg.pins.sclkS[1];
    r_next.pins.csPrev   = r_reg.pins.csS[1];
    r_next.pins.syncPrev = r_reg.pins.syncS[1];
    csLow    = ~r_reg.pins.csS[1];
    csFall   = r_reg.pins.csPrev & ~r_reg.pins.csS[1];
    sclkRise = csLow & r_reg.pins.sclkS[1] & ~r_reg.pins.sclkPrev;
    sclkFall = csLow & ~r_reg.pins.sclkS[1] & r_reg.pins.sclkPrev;
    syncFall = r_reg.pins.syncPrev & ~r_reg.pins.syncS[1];

    // ----------------------------------------------------------
    // wishbone slave: ack one cycle after the strobe, dropped next
    busHit       = wb_cyc_i & wb_stb_i & ~r_reg.ack;
    r_next.ack   = busHit;
    r_next.rdata = '0;
    if (busHit && !wb_we_i) begin
      unique case (wb_adr_i)
        OFS_CTRL:   r_next.rdata = cfg_word(r_reg.cfg);
        OFS_STATUS: begin
          r_next.rdata[STAT_STANDBY]  = r_reg.standby;
          r_next.rdata[STAT_POLARITY] = r_reg.polarity;
          r_next.rdata[STAT_CHOP]     = r_reg.cfg.chopEn;
          r_next.rdata[STAT_PHASE]    = r_reg.phaseOn;
          r_next.rdata[STAT_DCTEST]   = r_reg.dcOn;
          r_next.rdata[STAT_FIRST]    = r_reg.firstPend;
        end
        OFS_RESULT: r_next.rdata = {8'h00, r_reg.result};
        default:    r_next.rdata = '0;   // unmapped reads as zero
      endcase
    end
    if (busHit && wb_we_i && wb_adr_i == OFS_CTRL) begin
      // byte lanes merge into the current control word
      mask   = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
      wword  = (cfg_word(r_reg.cfg) & ~mask) | (wb_dat_i & mask);
      newCfg.chopEn   = wword[CTRL_CHOP];
      newCfg.dlySel   = wword[CTRL_DLY_LSB +: 4];
      newCfg.pwr      = wword[CTRL_PWR_LSB +: 2];
      newCfg.osrSel   = wword[CTRL_OSR_LSB +: 3];
      newCfg.isoEn    = wword[CTRL_ISO];
      newCfg.phaseReq = wword[CTRL_PHASE];
      newCfg.dcReq    = wword[CTRL_DCTEST];
      r_next.cfg      = newCfg;
      // a new ratio in chop mode restarts every channel together
      if (newCfg.chopEn && newCfg.osrSel != r_reg.cfg.osrSel) begin
        restart = 1'b1;
      end
      // switching mode starts a clean sequence too
      if (newCfg.chopEn != r_reg.cfg.chopEn) begin
        restart = 1'b1;
      end
    end

    // derived outputs of the configuration
    r_next.phaseOn = newCfg.phaseReq & ~newCfg.chopEn;
    r_next.dcOn    = newCfg.dcReq & ~newCfg.chopEn;

    // ----------------------------------------------------------
    // serial peripheral; chip select high parks everything
    if (!csLow) begin
      r_next.spi.bitCnt  = '0;
      r_next.spi.rx      = '0;
      r_next.spi.doutOeN = 1'b1;
      r_next.spi.dout    = 1'b0;
    end else begin
      r_next.spi.doutOeN = 1'b0;
      if (csFall) begin
        // response word: status byte then top result byte
        r_next.spi.tx = {2'h0, r_reg.firstPend, r_reg.dcOn, r_reg.phaseOn,
                         r_reg.cfg.chopEn, r_reg.polarity, r_reg.standby,
                         r_reg.result[23:16]};
      end
      if (sclkRise) begin
        r_next.spi.dout = r_reg.spi.tx[15];
        r_next.spi.tx   = {r_reg.spi.tx[14:0], 1'b0};
      end
      if (sclkFall) begin
        word              = {r_reg.spi.rx[14:0], r_reg.pins.dinS[1]};
        r_next.spi.rx     = word;
        r_next.spi.bitCnt = r_reg.spi.bitCnt + 5'h01;
        if (r_reg.spi.bitCnt == WORD_BITS - 5'h01) begin
          r_next.spi.bitCnt = '0;
          if (word == CMD_STANDBY) begin
            r_next.standby = 1'b1;
          end else if (word == CMD_WAKEUP && r_reg.standby) begin
            r_next.standby = 1'b0;
            restart        = 1'b1;
          end
        end
      end
    end

    // ----------------------------------------------------------
    // sync pin: falling edge restarts, long low resets
    if (!r_reg.pins.syncS[1]) begin
      if (r_reg.syncLow != 16'hFFFF) begin
        r_next.syncLow = r_reg.syncLow + 16'h0001;
      end
      if (r_reg.syncLow == RESET_LAST) begin
        softReset = 1'b1;
      end
    end else begin
      r_next.syncLow = '0;
    end
    // restart at the edge itself; a glitch shorter than the minimum is
    // filtered by the synchroniser sampling, not by waiting here
    if (syncFall) begin
      restart = 1'b1;
    end

    // ----------------------------------------------------------
    // modulator period timebase
    modTick       = (r_reg.modCnt == MOD_LAST);
    r_next.modCnt = modTick ? 16'h0000 : r_reg.modCnt + 16'h0001;
    osrLen  = OSR_BASE << r_reg.cfg.osrSel;
    convLen = r_reg.cfg.chopEn ? osrLen * CHOP_CONV_MUL : osrLen;
    dlyLen  = 32'h0000_0002 << r_reg.cfg.dlySel;
    // chop correction: reversed conversions are negated before averaging
    corr = r_reg.polarity ? -{convSample[23], convSample} : {convSample[23], convSample};
    sum  = corr + r_reg.prevCorr;

    // ----------------------------------------------------------
    // conversion sequencer
    unique case (r_reg.seq)
      SQ_DELAY: begin
        // inputs settle after the swap before the filter runs
        if (modTick) begin
          r_next.cnt = r_reg.cnt + 32'h0000_0001;
          if (r_reg.cnt == dlyLen - 32'h0000_0001) begin
            r_next.cnt = '0;
            r_next.seq = SQ_CONV;
          end
        end
      end
      SQ_CONV: begin
        if (modTick) begin
          r_next.cnt = r_reg.cnt + 32'h0000_0001;
          if (r_reg.cnt >= convLen - 32'h0000_0001) begin
            r_next.cnt = '0;
            if (!r_reg.cfg.chopEn) begin
              r_next.result = convSample;
              emit          = 1'b1;
            end else begin
              r_next.polarity = ~r_reg.polarity;
              r_next.prevCorr = corr;
              r_next.havePrev = 1'b1;
              r_next.seq      = SQ_DELAY;
              if (r_reg.havePrev) begin
                // every pair waits out the filter latency, so spacing stays one period
                r_next.pendResult = sum[24:1];
                r_next.extraCnt   = FIRST_EXTRA;
                r_next.firstPend  = 1'b0;
              end
            end
          end
        end
      end
      SQ_HALT: begin
        r_next.cnt = '0;
      end
      default: r_next.seq = SQ_HALT;
    endcase
    // output latency runs beside the next delay phase
    if (modTick && r_reg.extraCnt != 6'h00) begin
      r_next.extraCnt = r_reg.extraCnt - 6'h01;
      if (r_reg.extraCnt == 6'h01) begin
        r_next.result = r_reg.pendResult;
        emit          = 1'b1;
      end
    end
    // restart of all channels from a clean normal-polarity state
    if (restart) begin
      r_next.cnt       = '0;
      r_next.polarity  = 1'b0;
      r_next.havePrev  = 1'b0;
      r_next.extraCnt  = '0;
      r_next.firstPend = newCfg.chopEn;
      r_next.seq       = newCfg.chopEn ? SQ_DELAY : SQ_CONV;
      emit             = 1'b0;
    end
    // standby stops conversions but keeps configuration
    if (r_next.standby) begin
      r_next.seq      = SQ_HALT;
      r_next.extraCnt = '0;
      emit            = 1'b0;
    end

    // data ready: a low pulse per new result
    if (emit) begin
      r_next.drdyN   = 1'b0;
      r_next.drdyCnt = DATA_READY_N_LAST;
    end else if (r_reg.drdyCnt != 8'h00) begin
      r_next.drdyCnt = r_reg.drdyCnt - 8'h01;
    end else begin
      r_next.drdyN = 1'b1;
    end

    // long sync low: everything back to reset, pins keep tracking
    if (softReset) begin
      r_next         = ST_INIT;
      r_next.pins    = {r_reg.pins.sclkS[0], sclkPin, r_reg.pins.csS[0], csPinN,
                        r_reg.pins.dinS[0], dinPin, r_reg.pins.syncS[0], syncResetPinN,
                        r_reg.pins.sclkS[1], r_reg.pins.csS[1], r_reg.pins.syncS[1]};
      r_next.syncLow = r_reg.syncLow + 16'h0001;   // counts on, so no repeat while low
    end
    // copies registered here so every output comes straight from a flop
    r_next.filterRst = (r_next.seq != SQ_CONV);
    r_next.chanOn    = ~r_next.standby;
  end
  // ==========================================================
  // state register
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      r_reg <= ST_INIT;
    end else begin
      r_reg <= r_next;
    end
  end

  // ==========================================================
  // outputs, all straight from the state register
  assign wb_dat_o        = r_reg.rdata;
  assign wb_ack_o        = r_reg.ack;
  assign doutPin         = r_reg.spi.dout;
  assign doutOeN         = r_reg.spi.doutOeN;
  assign dataReadyN      = r_reg.drdyN;
  assign chopPolarity    = r_reg.polarity;
  assign filterReset     = r_reg.filterRst;
  assign channelEnable   = r_reg.chanOn;
  assign refPowerUp      = r_reg.chanOn;
  assign biasMode        = r_reg.cfg.pwr;
  assign phaseCalEnable  = r_reg.phaseOn;
  assign dcTestEnable    = r_reg.dcOn;
  assign isoSupplyEnable = r_reg.cfg.isoEn;

endmodule
